//--- hdl/ota_pkg.sv
// How it works
// [RL1] reset selects comparator mode
// [RL2] temperature above limit asserts alert
// [RL3] comparator releases below hysteresis only
// [RL4] comparator shutdown holds alert state
// [RL5] interrupt alert held until register read
// [RL6] after high event, rearm below hysteresis
// [RL7] after low event, rearm above limit
// [RL8] alert response also clears alert
// [RL9] interrupt shutdown entry clears alert
// [RL10] alert enable bit gates response
// [RL11] host selects interrupt mode too
// [RL12] open-drain alert pin, pull only
// [RL13] host uses active low when shared
// [RL14] shared line low if any pulls
// [RL15] host reads reserved response address
// [RL16] alerting device acks, returns own address
// [RL17] low bit shows which limit crossed
// [RL18] lowest address wins bus arbitration
// [RL19] alert released after address delivered
// [RL20] host repeats response read while low
// [RL21] address high nibble fixed, pins low
// [RL22] limits compared in temperature format
package ota_pkg;
    localparam logic [1:0]  OTA_REG_TEMP   = 2'h0;
    localparam logic [1:0]  OTA_REG_CFG    = 2'h1;
    localparam logic [1:0]  OTA_REG_HYST   = 2'h2;
    localparam logic [1:0]  OTA_REG_LIM    = 2'h3;
    localparam logic [15:0] OTA_TEMP_RST   = 16'h0000;
    localparam logic [15:0] OTA_HYST_RST   = 16'h4b00;
    localparam logic [15:0] OTA_LIM_RST    = 16'h5000;
    localparam logic [15:0] OTA_VAL_MASK   = 16'hfff0;
    localparam logic [7:0]  OTA_CFG_RST    = 8'h00;
    localparam logic [3:0]  OTA_ADDR_HI    = 4'h9;
    localparam logic [6:0]  OTA_ARA        = 7'h0c;
    localparam logic [3:0]  OTA_BYTE_BITS  = 4'h8;

    typedef struct packed {
        logic       alert_en;
        logic [3:0] spare;
        logic       pol_high;
        logic       int_mode;
        logic       shdn;
    } ota_cfg_s;

    typedef enum logic [4:0] {
        ARA_IDLE = 5'h01,
        ARA_ADDR = 5'h02,
        ARA_ACK  = 5'h04,
        ARA_DATA = 5'h08,
        ARA_SKIP = 5'h10
    } ota_ara_e;
endpackage

//--- hdl/ota_ara_resp.sv
`timescale 1ns/100ps
`default_nettype none
module ota_ara_resp
    import ota_pkg::*;
(
    input  wire logic       mclk_i,     // system clock
    input  wire logic       sys_rst_i,  // sync reset, high
    input  wire logic       scl_i,      // bus clock pin
    input  wire logic       sda_i,      // bus data pin
    input  wire logic [6:0] own_addr_i, // own bus address
    input  wire logic       lsb_i,      // limit indicator bit
    input  wire logic       armed_i,    // alert pending
    output logic            sda_o,      // data drive level
    output logic            sda_oe_o,   // data pull enable
    output logic            done_o      // address delivered
);
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    ota_ara_e   state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [2:0] next_scl_s;
    logic [2:0] next_sda_s;
    logic       next_scl_f;
    logic       next_sda_f;
    ota_ara_e   next_state;
    logic [3:0] next_cnt;
    logic [7:0] next_sh;
    logic [7:0] next_tx;
    logic       next_oe;
    logic       next_done;
    logic       scl_ok;
    logic       sda_ok;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;

    always_comb begin
        next_scl_s = {scl_s[1:0], scl_i};
        next_sda_s = {sda_s[1:0], sda_i};
        scl_ok     = scl_s[1] == scl_s[2];
        sda_ok     = sda_s[1] == sda_s[2];
        next_scl_f = scl_ok ? scl_s[2] : scl_f;
        next_sda_f = sda_ok ? sda_s[2] : sda_f;
        scl_rise   = scl_ok & scl_s[2] & ~scl_f;
        scl_fall   = scl_ok & ~scl_s[2] & scl_f;
        start      = sda_ok & ~sda_s[2] & sda_f & scl_f & scl_ok & scl_s[2];
        stop       = sda_ok & sda_s[2] & ~sda_f & scl_f & scl_ok & scl_s[2];
        next_state = state;
        next_cnt   = cnt;
        next_sh    = sh;
        next_tx    = tx;
        next_oe    = sda_oe_o;
        next_done  = 1'b0;
        if (start) begin
            next_state = ARA_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop) begin
            next_state = ARA_IDLE;
            next_oe    = 1'b0;
        end else begin
            case (state)
                ARA_ADDR: begin
                    if (scl_rise) begin
                        next_sh  = {sh[6:0], sda_f};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == OTA_BYTE_BITS) begin
                        if (sh == {OTA_ARA, 1'b1} && armed_i) begin
                            next_state = ARA_ACK;
                            next_oe    = 1'b1;                   // [RL16]
                            next_tx    = {own_addr_i, lsb_i};    // [RL17]
                        end else begin
                            next_state = ARA_SKIP;
                        end
                    end
                end
                ARA_ACK: begin
                    if (scl_fall) begin
                        next_state = ARA_DATA;
                        next_cnt   = 4'h0;
                        next_oe    = ~tx[7];
                        next_tx    = {tx[6:0], 1'b0};
                    end
                end
                ARA_DATA: begin
                    if (scl_rise) begin
                        // third sync stage of the line, same depth as the clock edge detect; the filtered copy lags it by a cycle
                        if (!sda_oe_o && !sda_s[2]) begin
                            next_state = ARA_SKIP;               // [RL18]
                        end else begin
                            next_cnt = cnt + 4'h1;
                        end
                    end else if (scl_fall) begin
                        if (cnt == OTA_BYTE_BITS) begin
                            next_oe    = 1'b0;
                            next_done  = 1'b1;                   // [RL19]
                            next_state = ARA_SKIP;
                        end else begin
                            next_oe = ~tx[7];
                            next_tx = {tx[6:0], 1'b0};
                        end
                    end
                end
                ARA_IDLE: begin
                    next_state = ARA_IDLE;
                end
                ARA_SKIP: begin
                    next_state = ARA_SKIP;
                end
                default: begin
                    next_state = ARA_IDLE;
                    next_oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            scl_s    <= 3'h7;
            sda_s    <= 3'h7;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            state    <= ARA_IDLE;
            cnt      <= 4'h0;
            sh       <= 8'h00;
            tx       <= 8'h00;
            sda_oe_o <= 1'b0;
            sda_o    <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            scl_s    <= next_scl_s;
            sda_s    <= next_sda_s;
            scl_f    <= next_scl_f;
            sda_f    <= next_sda_f;
            state    <= next_state;
            cnt      <= next_cnt;
            sh       <= next_sh;
            tx       <= next_tx;
            sda_oe_o <= next_oe;
            sda_o    <= 1'b0;
            done_o   <= next_done;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_ACK_ONLY_ARMED: assert property ($rose(sda_oe_o) && state == ARA_ACK |-> $past(armed_i)) // [RL16]
        else $error("ack given without pending alert");
    AST_DONE_RELEASES: assert property (done_o |-> !sda_oe_o ##1 !done_o) // [RL19]
        else $error("done not a released one-cycle pulse");
    AST_ARB_LOSS: assert property (state == ARA_DATA && scl_rise && !sda_oe_o && !sda_s[2] && !start && !stop
        |=> state == ARA_SKIP && !sda_oe_o [*2]) // [RL18]
        else $error("arbitration loss not honoured");
endmodule
`default_nettype wire

//--- hdl/ota_alert.sv
`timescale 1ns/100ps
`default_nettype none
module ota_alert
    import ota_pkg::*;
(
    input  wire logic        mclk_i,                     // 20 MHz clock
    input  wire logic        sys_rst_i,                  // sync reset, high
    input  wire logic [1:0]  addr_i,                     // register index
    input  wire logic [15:0] wdata_i,                    // write data
    input  wire logic        wr_i,                       // write strobe
    input  wire logic        rd_i,                       // read strobe
    output logic      [15:0] rdata_o,                    // read data, next cycle
    input  wire logic [15:0] temp_i,                     // converter result
    input  wire logic        temp_vld_i,                 // result strobe
    input  wire logic        addr_select_bit0_i,         // address pin 0
    input  wire logic        addr_select_bit1_i,         // address pin 1
    input  wire logic        addr_select_bit2_i,         // address pin 2
    input  wire logic        scl_i,                      // bus clock pin
    input  wire logic        sda_i,                      // bus data pin
    output logic             sda_o,                      // bus data level
    output logic             sda_oe_o,                   // bus data pull
    output logic             overtemp_alert_output_o,    // alert pin level
    output logic             overtemp_alert_output_oe_o, // alert pin pull
    output logic             alert_active_o              // alert logical state
);
    ota_cfg_s    cfg;
    logic [15:0] temp;
    logic [15:0] hyst;
    logic [15:0] lim;
    logic        exp_hi;
    logic        hi_flag;
    logic [2:0]  as_s1;
    logic [2:0]  as_s2;
    logic [2:0]  as_s3;
    logic [2:0]  as_q;
    logic        ara_done;
    logic        armed;
    ota_cfg_s    next_cfg;
    logic [15:0] next_temp;
    logic [15:0] next_hyst;
    logic [15:0] next_lim;
    logic        next_active;
    logic        next_exp_hi;
    logic        next_hi_flag;
    logic [15:0] next_rdata;
    logic [2:0]  next_as_q;
    logic        next_oe;
    ota_cfg_s    wr_cfg;
    logic        cfg_wr;
    logic        mode_chg;
    logic        shdn_entry;
    logic        take;
    logic        over;
    logic        under;
    logic [15:0] tval;

    function automatic logic [15:0] ota_align(input logic [15:0] v);
        ota_align = v & OTA_VAL_MASK;
    endfunction

    function automatic logic ota_gt(input logic [15:0] a, input logic [15:0] b);
        ota_gt = $signed(ota_align(a)) > $signed(ota_align(b));
    endfunction

    // address pins: three-stage sync, accepted once stages two and three agree
    always_comb begin
        next_as_q = (as_s2 == as_s3) ? as_s3 : as_q;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            as_s1 <= 3'h0;
            as_s2 <= 3'h0;
            as_s3 <= 3'h0;
            as_q  <= 3'h0;
        end else begin
            as_s1 <= {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i};
            as_s2 <= as_s1;
            as_s3 <= as_s2;
            as_q  <= next_as_q;
        end
    end

    // register file
    always_comb begin
        wr_cfg    = ota_cfg_s'(wdata_i[7:0]);
        cfg_wr    = wr_i && addr_i == OTA_REG_CFG;
        take      = temp_vld_i && !cfg.shdn;
        tval      = ota_align(temp_i);
        next_cfg  = cfg_wr ? wr_cfg : cfg;
        next_temp = take ? tval : temp;
        next_hyst = hyst;
        next_lim  = lim;
        if (wr_i && addr_i == OTA_REG_HYST) begin
            next_hyst = ota_align(wdata_i);                       // [RL22]
        end else if (wr_i && addr_i == OTA_REG_LIM) begin
            next_lim = ota_align(wdata_i);                        // [RL22]
        end
        next_rdata = 16'h0000;
        if (rd_i) begin
            if (addr_i == OTA_REG_TEMP) begin
                next_rdata = temp;
            end else if (addr_i == OTA_REG_CFG) begin
                next_rdata = {8'h00, cfg};
            end else if (addr_i == OTA_REG_HYST) begin
                next_rdata = hyst;
            end else begin
                next_rdata = lim;
            end
        end
    end

    // alert state: comparator or interrupt behaviour
    always_comb begin
        over         = ota_gt(temp_i, lim);                       // [RL2] [RL22]
        under        = ota_gt(hyst, temp_i);                      // [RL22]
        mode_chg     = cfg_wr && wr_cfg.int_mode != cfg.int_mode;
        shdn_entry   = cfg_wr && wr_cfg.shdn && !cfg.shdn;
        next_active  = alert_active_o;
        next_exp_hi  = exp_hi;
        next_hi_flag = take ? !ota_gt(lim, temp_i) : hi_flag;    // [RL17]
        if (mode_chg) begin
            next_active = 1'b0;
            next_exp_hi = 1'b1;
        end else if (cfg.int_mode) begin
            if (rd_i || ara_done || shdn_entry) begin
                next_active = 1'b0;                               // [RL5] [RL8] [RL9]
            end
            // a new event in the clearing cycle still sets the alert
            if (take && exp_hi && over) begin
                next_active = 1'b1;                               // [RL2] [RL7]
                next_exp_hi = 1'b0;
            end else if (take && !exp_hi && under) begin
                next_active = 1'b1;                               // [RL6]
                next_exp_hi = 1'b1;
            end
        end else begin
            // no samples are taken in shutdown, so the state holds
            if (take && over) begin
                next_active = 1'b1;                               // [RL2] [RL4]
            end else if (take && under) begin
                next_active = 1'b0;                               // [RL3]
            end
        end
        armed   = alert_active_o && cfg.alert_en && cfg.int_mode; // [RL10] [RL11]
        next_oe = next_active ^ next_cfg.pol_high;                // [RL12] [RL14]
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cfg                        <= ota_cfg_s'(OTA_CFG_RST); // [RL1]
            temp                       <= OTA_TEMP_RST;
            hyst                       <= OTA_HYST_RST;
            lim                        <= OTA_LIM_RST;
            exp_hi                     <= 1'b1;
            hi_flag                    <= 1'b0;
            alert_active_o             <= 1'b0;
            rdata_o                    <= 16'h0000;
            overtemp_alert_output_o    <= 1'b0;
            overtemp_alert_output_oe_o <= 1'b0;
        end else begin
            cfg                        <= next_cfg;
            temp                       <= next_temp;
            hyst                       <= next_hyst;
            lim                        <= next_lim;
            exp_hi                     <= next_exp_hi;
            hi_flag                    <= next_hi_flag;
            alert_active_o             <= next_active;
            rdata_o                    <= next_rdata;
            overtemp_alert_output_o    <= 1'b0;                   // [RL12]
            overtemp_alert_output_oe_o <= next_oe;
        end
    end

    ota_ara_resp u_ara (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .own_addr_i ({OTA_ADDR_HI, as_q}),                        // [RL21]
        .lsb_i      (hi_flag),
        .armed_i    (armed),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .done_o     (ara_done)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_RESET_COMPARATOR: assert property ($fell(sys_rst_i) |-> !cfg.int_mode && !alert_active_o) // [RL1]
        else $error("reset did not select comparator mode");
    AST_OVER_SETS: assert property (take && over && !mode_chg && (!cfg.int_mode || exp_hi)
        |=> alert_active_o) // [RL2]
        else $error("over-limit sample did not assert alert");
    AST_CMP_HOLDS: assert property (!cfg.int_mode && !take && !mode_chg |=> $stable(alert_active_o)) // [RL3]
        else $error("comparator alert changed without a sample");
    AST_CMP_SHDN_HOLD: assert property (!cfg.int_mode && cfg.shdn && !cfg_wr
        |=> $stable(alert_active_o) && $stable(temp)) // [RL4]
        else $error("comparator alert changed in shutdown");
    AST_INT_READ_CLEARS: assert property (cfg.int_mode && rd_i && !take && !cfg_wr
        |=> !alert_active_o ##1 (rdata_o == 16'h0000 || $past(rd_i))) // [RL5]
        else $error("register read did not clear interrupt alert");
    AST_INT_REARM_LOW: assert property (cfg.int_mode && !exp_hi && take && !under && !mode_chg
        |=> !$rose(alert_active_o) && !exp_hi) // [RL6]
        else $error("interrupt rearmed without a low sample");
    AST_INT_REARM_HIGH: assert property (cfg.int_mode && exp_hi && take && !over && !mode_chg
        |=> !$rose(alert_active_o) && exp_hi) // [RL7]
        else $error("interrupt rearmed without a high sample");
    AST_ARA_CLEARS: assert property (cfg.int_mode && ara_done && !take && !cfg_wr |=> !alert_active_o) // [RL8]
        else $error("alert response did not clear alert");
    AST_INT_SHDN_CLEARS: assert property (cfg.int_mode && shdn_entry && wr_cfg.int_mode && !take
        |=> !alert_active_o) // [RL9]
        else $error("shutdown entry did not clear interrupt alert");
    AST_PIN_OPEN_DRAIN: assert property (!overtemp_alert_output_o
        && overtemp_alert_output_oe_o == (alert_active_o ^ cfg.pol_high)) // [RL12]
        else $error("alert pin drive wrong");
endmodule
`default_nettype wire

//--- dv/ota_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ota_host_model (
    input  wire logic sda_i,    // wired data line
    output logic      scl_o,    // bus clock level
    output logic      sda_oe_o  // pull data line low
);
    // reserved response address with the read bit
    localparam logic [7:0] ARA_RD = {7'h0c, 1'b1};

    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    // one 400 ns bit slot; sampled mid-high to clear the slave's sync delay
    task automatic slot(input logic pull, output logic seen);
        #100 sda_oe_o = pull;
        #100 scl_o = 1'b1;
        #100 seen = sda_i;
        #100 scl_o = 1'b0;
    endtask

    // rival stands for a lower-address device answering in the same frame
    task automatic ara_read(input logic rival, input logic [7:0] rival_byte,
                            output logic ack, output logic [7:0] data);
        logic b;
        sda_oe_o = 1'b1;
        #200 scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            slot(~ARA_RD[i], b);
        end
        slot(rival, b);
        ack = ~b;
        for (int i = 7; i >= 0; i--) begin
            slot(rival & ~rival_byte[i], data[i]);
        end
        slot(1'b0, b);
        #100 sda_oe_o = 1'b1;
        #100 scl_o = 1'b1;
        #100 sda_oe_o = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

//--- dv/overtemp_alert_logic_test.sv
`timescale 1ns/100ps
`default_nettype none
module overtemp_alert_logic_test
    import ota_pkg::*;
;
    logic        mclk_i;
    logic        sys_rst_i;
    logic [1:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic [15:0] temp_i;
    logic        temp_vld_i;
    logic [2:0]  pins;
    logic        scl;
    logic        host_oe;
    logic        sda_line;
    logic        sda_o;
    logic        sda_oe_o;
    logic        alert_o;
    logic        alert_oe_o;
    logic        alert_active_o;
    logic        other_oe;
    logic        alert_line;
    logic        exp_pol;
    int          failures;
    int          n_tests;

    assign sda_line   = ~(sda_oe_o | host_oe);
    assign alert_line = ~(alert_oe_o | other_oe);

    ota_alert uut (
        .mclk_i                     (mclk_i),
        .sys_rst_i                  (sys_rst_i),
        .addr_i                     (addr_i),
        .wdata_i                    (wdata_i),
        .wr_i                       (wr_i),
        .rd_i                       (rd_i),
        .rdata_o                    (rdata_o),
        .temp_i                     (temp_i),
        .temp_vld_i                 (temp_vld_i),
        .addr_select_bit0_i         (pins[0]),
        .addr_select_bit1_i         (pins[1]),
        .addr_select_bit2_i         (pins[2]),
        .scl_i                      (scl),
        .sda_i                      (sda_line),
        .sda_o                      (sda_o),
        .sda_oe_o                   (sda_oe_o),
        .overtemp_alert_output_o    (alert_o),
        .overtemp_alert_output_oe_o (alert_oe_o),
        .alert_active_o             (alert_active_o)
    );

    ota_host_model host (
        .sda_i    (sda_line),
        .scl_o    (scl),
        .sda_oe_o (host_oe)
    );

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        chk_word("rdata", exp, rdata_o);
        @(posedge mclk_i);
        #1;
        chk_word("rdata_idle", 16'h0000, rdata_o);
    endtask

    task automatic samp(input logic [15:0] t);
        @(posedge mclk_i);
        temp_i     <= t;
        temp_vld_i <= 1'b1;
        @(posedge mclk_i);
        temp_vld_i <= 1'b0;
    endtask

    task automatic alert_is(input logic e);
        @(posedge mclk_i);
        #1;
        chk_bit("alert_active", e, alert_active_o);
        chk_bit("alert_oe", e ^ exp_pol, alert_oe_o);
        chk_bit("alert_level", 1'b0, alert_o);
    endtask

    task automatic ara(input logic rival, input logic [7:0] rbyte, input logic exp_ack, input logic [7:0] exp_byte);
        logic       ack;
        logic [7:0] data;
        // keep link edges off the clock edge
        @(posedge mclk_i);
        #1;
        host.ara_read(rival, rbyte, ack, data);
        chk_bit("ara_ack", exp_ack, ack);
        chk_bit("sda_level", 1'b0, sda_o);
        if (exp_ack) begin
            chk_word("ara_byte", {8'h00, exp_byte}, {8'h00, data});
        end
    endtask

    initial begin
        #1_000_000;
        failures++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        sys_rst_i  = 1'b1;
        addr_i     = 2'h0;
        wdata_i    = 16'h0000;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        temp_i     = 16'h0000;
        temp_vld_i = 1'b0;
        pins       = 3'b101;
        other_oe   = 1'b0;
        exp_pol    = 1'b0;
        failures   = 0;
        n_tests    = 0;
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        alert_is(1'b0);
        rd_chk(OTA_REG_CFG, 16'h0000);
        rd_chk(OTA_REG_HYST, OTA_HYST_RST);
        rd_chk(OTA_REG_LIM, OTA_LIM_RST);
        wr(OTA_REG_TEMP, 16'h1234);
        rd_chk(OTA_REG_TEMP, 16'h0000);
        test_end("reset");
        wr(OTA_REG_LIM, 16'h190f);
        rd_chk(OTA_REG_LIM, 16'h1900);
        wr(OTA_REG_HYST, 16'h1400);
        samp(16'h190f);
        alert_is(1'b0);
        samp(16'h1910);
        alert_is(1'b1);
        chk_bit("alert_line", 1'b0, alert_line);
        rd_chk(OTA_REG_TEMP, 16'h1910);
        samp(16'h1400);
        alert_is(1'b1);
        wr(OTA_REG_CFG, 16'h0001);
        samp(16'hff00);
        alert_is(1'b1);
        wr(OTA_REG_CFG, 16'h0000);
        samp(16'hff00);
        alert_is(1'b0);
        exp_pol = 1'b1;
        wr(OTA_REG_CFG, 16'h0004);
        alert_is(1'b0);
        samp(16'h1a00);
        alert_is(1'b1);
        test_end("comparator");
        exp_pol = 1'b0;
        wr(OTA_REG_CFG, 16'h0002);
        alert_is(1'b0);
        samp(16'h1a00);
        alert_is(1'b1);
        rd_chk(OTA_REG_HYST, 16'h1400);
        alert_is(1'b0);
        samp(16'h1a00);
        alert_is(1'b0);
        samp(16'h1300);
        alert_is(1'b1);
        rd_chk(OTA_REG_CFG, 16'h0002);
        alert_is(1'b0);
        samp(16'h1300);
        alert_is(1'b0);
        samp(16'h1910);
        alert_is(1'b1);
        wr(OTA_REG_CFG, 16'h0003);
        alert_is(1'b0);
        test_end("interrupt");
        wr(OTA_REG_CFG, 16'h0000);
        // alert enable, interrupt mode, active low for the shared line
        wr(OTA_REG_CFG, 16'h0082);
        ara(1'b0, 8'h00, 1'b0, 8'h00);
        samp(16'h1a00);
        alert_is(1'b1);
        chk_bit("alert_line", 1'b0, alert_line);
        ara(1'b0, 8'h00, 1'b1, {OTA_ADDR_HI, 3'b101, 1'b1});
        alert_is(1'b0);
        pins <= 3'b010;
        samp(16'h1300);
        alert_is(1'b1);
        ara(1'b1, 8'h90, 1'b1, 8'h90);
        alert_is(1'b1);
        chk_bit("alert_line", 1'b0, alert_line);
        if (alert_line === 1'b0) begin
            ara(1'b0, 8'h00, 1'b1, {OTA_ADDR_HI, 3'b010, 1'b0});
        end
        alert_is(1'b0);
        other_oe = 1'b1;
        #1;
        chk_bit("alert_line", 1'b0, alert_line);
        other_oe = 1'b0;
        test_end("alert response");
        wr(OTA_REG_CFG, 16'h0002);
        samp(16'h1a00);
        alert_is(1'b1);
        ara(1'b0, 8'h00, 1'b0, 8'h00);
        alert_is(1'b1);
        rd_chk(OTA_REG_CFG, 16'h0002);
        alert_is(1'b0);
        test_end("alert disabled");
        final_report();
    end
endmodule
`default_nettype wire
